/* File: bench/acd_exec_bench.sv */
module acd_exec_bench
    import acd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rstn, vld, cmp, cst, pst, cy, dn, skn, skd, ex;
    logic [9:0] code;
    logic [3:0] mem, ctl, acc;
    int fails = 0;
    int checks = 0;
    acd_exec acd_exec_i (.clk_i(clk), .rstn_i(rstn), .instr_valid_i(vld), .instr_code_i(code),
        .pointed_memory_word_i(mem), .converter_control_reg_i(ctl), .conversion_complete_i(cmp),
        .accumulator_o(acc), .carry_flag_o(cy), .conversion_done_flag_o(dn), .skip_next_o(skn),
        .instr_skipped_o(skd), .conversion_start_o(cst), .comparator_start_o(pst),
        .instr_executed_o(ex));
    acd_far_model acd_far_model_i (.clk_i(clk), .rstn_i(rstn), .start_i(cst | pst),
        .complete_o(cmp));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // Valid is left high so back-to-back slots never toggle within one step
    task op(input logic [9:0] c, input logic [3:0] m);
        vld = 1;
        code = c;
        mem = m;
        @(negedge clk);
    endtask
    task idle(input int n);
        vld = 0;
        repeat (n) @(negedge clk);
    endtask
    task t_mem;
        op(ADD_MEM_CODE, 4'h9);
        chk({cy, acc}, 5'h09);
        chk(ex, 1'b1);
        op(ADD_MEM_CY_CODE, 4'h7);
        chk({cy, acc}, 5'h10);
        op(ADD_MEM_CODE, 4'h2);
        chk({cy, acc}, 5'h12);
        op(ADD_MEM_CY_CODE, 4'h5);
        chk({cy, acc}, 5'h08);
        op(ADD_MEM_CY_CODE, 4'hF);
        chk({cy, acc}, 5'h17);
    endtask
    task t_imm;
        op(ADD_IMM_CODE | 10'h00F, 4'h0);
        chk({cy, skn, acc}, 6'h26);
        op(ADD_IMM_CODE | 10'h001, 4'h0);
        chk({cy, skn, acc}, 6'h37);
        op(ADD_IMM_CODE | 10'h001, 4'h0);
        chk({skd, skn, acc}, 6'h27);
        chk(ex, 1'b0);
        op(ADD_IMM_CODE | 10'h009, 4'h0);
        chk({cy, skn, acc}, 6'h20);
        idle(1);
    endtask
    task t_conv;
        ctl = 4'h0;
        op(CONV_START_CODE, 4'h0);
        chk({cst, pst, dn}, 3'b100);
        idle(6);
        chk(dn, 1'b1);
        ctl = 4'h8;
        op(CONV_START_CODE, 4'h0);
        chk({cst, pst, dn}, 3'b010);
        idle(6);
        op(SKIP_DONE_CODE, 4'h0);
        chk({skn, dn}, 2'b10);
        op(SKIP_DONE_CODE, 4'h0);
        chk({skd, skn}, 2'b10);
        op(SKIP_DONE_CODE, 4'h0);
        chk({skn, dn, ex}, 3'b001);
        idle(1);
    endtask
    task stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Whole sequence needs well under 100 cycles
    initial begin
        #(400 * 25);
        fails++;
        stop_test;
    end
    initial begin
        {rstn, vld, code, mem, ctl} = '0;
        repeat (12) @(negedge clk);
        rstn = 1;
        t_mem;
        t_imm;
        t_conv;
        stop_test;
    end
endmodule

/* File: bench/acd_exec_chk.sv */
module acd_exec_chk
    import acd_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       instr_valid_i,
    input wire logic [9:0] instr_code_i,
    input wire logic [3:0] pointed_memory_word_i,
    input wire logic [3:0] converter_control_reg_i,
    input wire logic       conversion_complete_i,
    input wire logic [3:0] accumulator_o,
    input wire logic       carry_flag_o,
    input wire logic       conversion_done_flag_o,
    input wire logic       skip_next_o,
    input wire logic       instr_skipped_o,
    input wire logic       conversion_start_o,
    input wire logic       comparator_start_o,
    input wire logic       instr_executed_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Taken instructions and five-bit sums, top bit is overflow
    wire       tk  = instr_valid_i && !skip_next_o;
    wire [4:0] si  = accumulator_o + instr_code_i[3:0];
    wire [4:0] sm  = accumulator_o + pointed_memory_word_i + carry_flag_o;
    wire [4:0] sa  = accumulator_o + pointed_memory_word_i;
    wire       imm = tk && (instr_code_i & ADD_IMM_MASK) == ADD_IMM_CODE;
    wire       cvs = tk && instr_code_i == CONV_START_CODE;
    wire       snz = tk && instr_code_i == SKIP_DONE_CODE;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_squash;
        instr_skipped_o && !skip_next_o && !instr_executed_o;
    endsequence
    a_imm_sum: assert property (imm |=> accumulator_o == $past(si[3:0]))
        else $error("immediate sum wrong");
    a_imm_carry: assert property (imm |=> $stable(carry_flag_o))
        else $error("immediate add moved carry");
    a_imm_skip: assert property (imm |=> skip_next_o == !$past(si[4]))
        else $error("immediate skip wrong");
    a_squash_slot: assert property (instr_valid_i && skip_next_o |=> s_squash)
        else $error("squash slot wrong");
    a_mem_sum: assert property (tk && instr_code_i == ADD_MEM_CODE |=>
        accumulator_o == $past(sa[3:0]) && $stable(carry_flag_o))
        else $error("memory add wrong");
    a_memc_sum: assert property (tk && instr_code_i == ADD_MEM_CY_CODE |=>
        {carry_flag_o, accumulator_o} == $past(sm))
        else $error("carry add wrong");
    a_conv_go: assert property (cvs && !converter_control_reg_i[CMP_MODE_BIT] |=>
        conversion_start_o && !comparator_start_o)
        else $error("conversion start wrong");
    a_cmp_go: assert property (cvs && converter_control_reg_i[CMP_MODE_BIT] |=>
        comparator_start_o && !conversion_start_o)
        else $error("comparator start wrong");
    a_done_clear: assert property (cvs |=>
        conversion_done_flag_o == $past(conversion_complete_i))
        else $error("done flag not cleared");
    a_skip_done: assert property (snz && conversion_done_flag_o |=>
        skip_next_o && conversion_done_flag_o == $past(conversion_complete_i))
        else $error("done skip wrong");
    a_exec_mark: assert property (imm || cvs || snz |=> instr_executed_o)
        else $error("executed mark missing");
endmodule
bind acd_exec acd_exec_chk acd_exec_chk_i (.*);

/* File: bench/acd_far_model.sv */
// Converter side: completes a few cycles after either start pulse
module acd_far_model (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic start_i,
    output logic      complete_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] busy_q;
    // Fixed latency keeps the bench wait exact
    always_ff @(posedge clk_i) begin
        busy_q <= rstn_i ? {busy_q[2:0], start_i} : 4'h0;
    end
    assign complete_o = busy_q[3];
endmodule

/* File: design/acd_add_if.sv */
// Operands and result of the 4-bit accumulator adder
interface acd_add_if;
    import acd_pkg::*;
    logic [WORD_W-1:0] op_a;
    logic [WORD_W-1:0] op_b;
    logic              carry_in;
    logic [WORD_W-1:0] sum;
    logic              carry_out;

    modport user (output op_a, output op_b, output carry_in, input sum, input carry_out);
    modport adder (input op_a, input op_b, input carry_in, output sum, output carry_out);
endinterface

/* File: design/acd_adder.sv */
// Modulo-16 adder; carry out of bit 3 doubles as the overflow indication
module acd_adder
    import acd_pkg::*;
(
    acd_add_if.adder add_if
);
    logic [WORD_W:0] wide_sum;

    // One extra bit keeps the carry out of bit 3
    assign wide_sum = {1'b0, add_if.op_a} + {1'b0, add_if.op_b}
                    + {{WORD_W{1'b0}}, add_if.carry_in};  // [RL9]
    assign add_if.sum       = wide_sum[WORD_W-1:0];       // [RL9]
    assign add_if.carry_out = wide_sum[WORD_W];           // [RL9]
endmodule

/* File: design/acd_exec.sv */
// Function
// [RL1] Immediate add puts accumulator plus 4-bit immediate into accumulator in one cycle.
// [RL2] Immediate add never touches the carry flag.
// [RL3] Immediate add skips next instruction when no overflow, else runs it.
// [RL4] Convert start clears done flag, then starts conversion when control bit 3 is 0.
// [RL5] With compare mode bit set, convert start begins a comparator operation instead.
// [RL6] Memory add puts accumulator plus pointed word into accumulator; carry unchanged.
// [RL7] Memory add with carry sums accumulator, pointed word, carry; carry takes carry out.
// [RL8] Skip on done: when done flag set, skip next instruction and clear flag.
// [RL9] Additions are modulo 16; carry out of bit 3 is the overflow.
module acd_exec
    import acd_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                instr_valid_i,
    input  wire logic [OPCODE_W-1:0] instr_code_i,
    input  wire logic [WORD_W-1:0]   pointed_memory_word_i,
    input  wire logic [WORD_W-1:0]   converter_control_reg_i,
    input  wire logic                conversion_complete_i,
    output logic [WORD_W-1:0]        accumulator_o,
    output logic                     carry_flag_o,
    output logic                     conversion_done_flag_o,
    output logic                     skip_next_o,
    output logic                     instr_skipped_o,
    output logic                     conversion_start_o,
    output logic                     comparator_start_o,
    output logic                     instr_executed_o
);
    logic [WORD_W-1:0] acc_q;
    logic [WORD_W-1:0] acc_d;
    logic              carry_q;
    logic              carry_d;
    logic              done_q;
    logic              done_d;
    logic              skip_q;
    logic              skip_d;
    logic              conv_start_q;
    logic              conv_start_d;
    logic              cmp_start_q;
    logic              cmp_start_d;
    logic              skipped_q;
    logic              skipped_d;
    logic              executed_q;
    logic              executed_d;

    acd_op_type        op;
    acd_add_if         add_bus ();

    // Decode; an instruction fetched while a skip is pending is squashed
    wire               take       = instr_valid_i && !skip_q;
    wire               squash     = instr_valid_i && skip_q;
    wire               is_add_imm = (instr_code_i & ADD_IMM_MASK) == ADD_IMM_CODE;
    wire               is_add_mem = instr_code_i == ADD_MEM_CODE;
    wire               is_add_cy  = instr_code_i == ADD_MEM_CY_CODE;
    wire               is_conv    = instr_code_i == CONV_START_CODE;
    wire               is_snz     = instr_code_i == SKIP_DONE_CODE;
    wire [WORD_W-1:0]  imm_value  = instr_code_i[IMM_MSB:IMM_LSB];
    wire               cmp_mode   = converter_control_reg_i[CMP_MODE_BIT];

    // Priority order is irrelevant since the codes are disjoint
    always_comb begin
        op = ACD_OP_NONE;
        if (take) begin
            if (is_add_imm) begin
                op = ACD_OP_ADD_IMM;
            end else if (is_add_mem) begin
                op = ACD_OP_ADD_MEM;
            end else if (is_add_cy) begin
                op = ACD_OP_ADD_MEM_CY;
            end else if (is_conv) begin
                op = ACD_OP_CONV_START;
            end else if (is_snz) begin
                op = ACD_OP_SKIP_DONE;
            end
        end
    end

    // Adder operands; carry enters only for the memory-with-carry form
    assign add_bus.op_a     = acc_q;
    assign add_bus.op_b     = (op == ACD_OP_ADD_IMM) ? imm_value : pointed_memory_word_i; // [RL1]
    assign add_bus.carry_in = (op == ACD_OP_ADD_MEM_CY) ? carry_q : 1'b0;                 // [RL7]

    acd_adder u_adder (
        .add_if (add_bus.adder)
    );

    // Accumulator and carry; only the three add forms write them
    always_comb begin
        acc_d   = acc_q;
        carry_d = carry_q;
        unique case (op)
            ACD_OP_NONE, ACD_OP_CONV_START, ACD_OP_SKIP_DONE: begin
            end
            ACD_OP_ADD_IMM: begin
                acc_d = add_bus.sum;              // [RL1] [RL9] carry stays put [RL2]
            end
            ACD_OP_ADD_MEM: begin
                acc_d = add_bus.sum;              // [RL6] carry stays put
            end
            ACD_OP_ADD_MEM_CY: begin
                acc_d   = add_bus.sum;            // [RL7]
                carry_d = add_bus.carry_out;      // [RL7] [RL9]
            end
        endcase
    end

    // Done flag, pending skip and the event pulses
    always_comb begin
        done_d       = done_q;
        skip_d       = skip_q;
        conv_start_d = 1'b0;
        cmp_start_d  = 1'b0;
        skipped_d    = squash;
        executed_d   = op != ACD_OP_NONE;
        if (squash) begin
            skip_d = 1'b0;  // The squashed slot consumes the pending skip
        end
        unique case (op)
            ACD_OP_NONE, ACD_OP_ADD_MEM, ACD_OP_ADD_MEM_CY: begin
            end
            ACD_OP_ADD_IMM: begin
                skip_d = !add_bus.carry_out;      // [RL3]
            end
            ACD_OP_CONV_START: begin
                done_d       = 1'b0;              // [RL4]
                conv_start_d = !cmp_mode;         // [RL4]
                cmp_start_d  = cmp_mode;          // [RL5]
            end
            ACD_OP_SKIP_DONE: begin
                if (done_q) begin
                    skip_d = 1'b1;                // [RL8]
                    done_d = 1'b0;                // [RL8]
                end
            end
        endcase
        // A completion in the clearing cycle must not be lost
        if (conversion_complete_i) begin
            done_d = 1'b1;
        end
    end

    // Accumulator register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_q <= ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Carry flag; only the carry-add form moves it
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            carry_q <= CARRY_RESET;
        end else begin
            carry_q <= carry_d;
        end
    end

    // Done flag; set wins over clear in the next-state logic
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            done_q <= DONE_RESET;
        end else begin
            done_q <= done_d;
        end
    end

    // Pending skip; cleared at reset so the first slot always runs
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            skip_q <= SKIP_RESET;
        end else begin
            skip_q <= skip_d;
        end
    end

    // Conversion start pulse, registered so it is glitch free
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            conv_start_q <= PULSE_RESET;
        end else begin
            conv_start_q <= conv_start_d;
        end
    end

    // Comparator start pulse
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cmp_start_q <= PULSE_RESET;
        end else begin
            cmp_start_q <= cmp_start_d;
        end
    end

    // Squashed-slot marker, one cycle late like every other output
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            skipped_q <= PULSE_RESET;
        end else begin
            skipped_q <= skipped_d;
        end
    end

    // Executed marker; unknown codes leave it low
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            executed_q <= PULSE_RESET;
        end else begin
            executed_q <= executed_d;
        end
    end

    // All outputs straight from flip-flops
    assign accumulator_o          = acc_q;
    assign carry_flag_o           = carry_q;
    assign conversion_done_flag_o = done_q;
    assign skip_next_o            = skip_q;
    assign instr_skipped_o        = skipped_q;
    assign conversion_start_o     = conv_start_q;
    assign comparator_start_o     = cmp_start_q;
    assign instr_executed_o       = executed_q;
endmodule

/* File: design/acd_pkg.sv */
package acd_pkg;
    localparam int unsigned WORD_W   = 4;
    localparam int unsigned OPCODE_W = 10;

    // Instruction encodings and the mask that strips the immediate field
    localparam logic [9:0] ADD_IMM_CODE    = 10'h060;
    localparam logic [9:0] ADD_IMM_MASK    = 10'h3F0;
    localparam logic [9:0] ADD_MEM_CODE    = 10'h00A;
    localparam logic [9:0] ADD_MEM_CY_CODE = 10'h00B;
    localparam logic [9:0] CONV_START_CODE = 10'h29F;
    localparam logic [9:0] SKIP_DONE_CODE  = 10'h287;

    // Field positions
    localparam int unsigned IMM_LSB         = 0;
    localparam int unsigned IMM_MSB         = 3;
    localparam int unsigned CMP_MODE_BIT    = 3;

    // Reset values
    localparam logic [3:0] ACC_RESET   = 4'h0;
    localparam logic       CARRY_RESET = 1'b0;
    localparam logic       DONE_RESET  = 1'b0;
    localparam logic       SKIP_RESET  = 1'b0;
    localparam logic       PULSE_RESET = 1'b0;

    typedef enum logic [2:0] {
        ACD_OP_NONE,
        ACD_OP_ADD_IMM,
        ACD_OP_ADD_MEM,
        ACD_OP_ADD_MEM_CY,
        ACD_OP_CONV_START,
        ACD_OP_SKIP_DONE
    } acd_op_type;
endpackage
